//--- hdl/motor_startup_config_bank.sv
// APB slave holding the start-up configuration word and decoding it for the sequencer.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "startup_consts.svh"

module motor_startup_config_bank import startup_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Settings to the start-up sequencer
  output startup_settings_t settings
);

  ////////////////////////////////////////////////////////////////////////////
  // Lookup tables

  function automatic logic [13:0] hold_time_lookup(input logic [3:0] code);
    unique case (code)
      4'h0: hold_time_lookup = 14'd10;
      4'h1: hold_time_lookup = 14'd50;
      4'h2: hold_time_lookup = 14'd100;
      4'h3: hold_time_lookup = 14'd200;
      4'h4: hold_time_lookup = 14'd300;
      4'h5: hold_time_lookup = 14'd400;
      4'h6: hold_time_lookup = 14'd500;
      4'h7: hold_time_lookup = 14'd750;
      4'h8: hold_time_lookup = 14'd1000;
      4'h9: hold_time_lookup = 14'd1500;
      4'hA: hold_time_lookup = 14'd2000;
      4'hB: hold_time_lookup = 14'd3000;
      4'hC: hold_time_lookup = 14'd4000;
      4'hD: hold_time_lookup = 14'd5000;
      4'hE: hold_time_lookup = 14'd7500;
      4'hF: hold_time_lookup = 14'd10000;
    endcase
  endfunction

  // Hold current in 1/128 A; reserved codes fall back to zero so nothing is driven.
  function automatic logic [8:0] hold_cap_lookup(input logic [3:0] code);
    unique case (code)
      4'h0: hold_cap_lookup = 9'd10;
      4'h1: hold_cap_lookup = 9'd20;
      4'h2: hold_cap_lookup = 9'd40;
      4'h3: hold_cap_lookup = 9'd80;
      4'h4: hold_cap_lookup = 9'd120;
      4'h5: hold_cap_lookup = 9'd160;
      4'h6: hold_cap_lookup = 9'd200;
      4'h7: hold_cap_lookup = 9'd240;
      4'h8: hold_cap_lookup = 9'd280;
      4'h9: hold_cap_lookup = 9'd320;
      4'hA: hold_cap_lookup = 9'd360;
      4'hB: hold_cap_lookup = 9'd400;
      4'hC: hold_cap_lookup = 9'd440;
      4'hD: hold_cap_lookup = 9'd480;
      4'hE, 4'hF: hold_cap_lookup = 9'd0;
    endcase
  endfunction

  function automatic logic [13:0] probe_rate_lookup(input logic [2:0] code);
    unique case (code)
      3'h0: probe_rate_lookup = 14'd50;
      3'h1: probe_rate_lookup = 14'd100;
      3'h2: probe_rate_lookup = 14'd250;
      3'h3: probe_rate_lookup = 14'd500;
      3'h4: probe_rate_lookup = 14'd1000;
      3'h5: probe_rate_lookup = 14'd2000;
      3'h6: probe_rate_lookup = 14'd5000;
      3'h7: probe_rate_lookup = 14'd10000;
    endcase
  endfunction

  // Trip level in 1/128 A, rounded to the nearest step where the level is not exact.
  function automatic logic [8:0] probe_trip_lookup(input logic [4:0] code);
    case (code)
      5'h00: probe_trip_lookup = 9'd20;
      5'h01: probe_trip_lookup = 9'd40;
      5'h02: probe_trip_lookup = 9'd60;
      5'h03: probe_trip_lookup = 9'd80;
      5'h04: probe_trip_lookup = 9'd100;
      5'h05: probe_trip_lookup = 9'd120;
      5'h06: probe_trip_lookup = 9'd160;
      5'h07: probe_trip_lookup = 9'd200;
      5'h08: probe_trip_lookup = 9'd240;
      5'h09: probe_trip_lookup = 9'd293;
      5'h0A: probe_trip_lookup = 9'd320;
      5'h0B: probe_trip_lookup = 9'd360;
      5'h0C: probe_trip_lookup = 9'd400;
      5'h0D: probe_trip_lookup = 9'd427;
      5'h0E: probe_trip_lookup = 9'd480;
      default: probe_trip_lookup = 9'd0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  localparam logic [ADDR_W-1:0] REG_ADDR = ADDR_W'(`STARTUP1_ADDR);

  logic [31:0] config_reg;
  logic [31:0] config_next;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  startup_settings_t settings_reg;
  startup_settings_t settings_next;

  wire setup_phase = psel && !penable;
  wire access_done = psel && penable && pready_reg;
  wire addr_hit = (paddr == REG_ADDR);
  wire write_hit = access_done && pwrite && addr_hit;
  wire [31:0] read_value = addr_hit ? (config_reg & `STARTUP1_WMASK) : 32'h0000_0000;
  wire [31:0] read_load = (setup_phase && !pwrite) ? read_value : 32'h0000_0000;
  wire error_load = setup_phase && !addr_hit;

  // Byte lanes are merged one at a time so a partial write keeps the other fields.
  logic [31:0] merged_write;
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign merged_write[lane*8 +: 8] = pstrb[lane] ? pwdata[lane*8 +: 8] : config_reg[lane*8 +: 8];
    end
  endgenerate

  // Bit 31 never stores, so it cannot leak into a read.
  assign config_next = write_hit ? (merged_write & `STARTUP1_WMASK) : config_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  wire [3:0] ramp_code = config_reg[`RAMP_HI:`RAMP_LO];
  wire [3:0] hold_cap_code = config_reg[`HOLD_CAP_HI:`HOLD_CAP_LO];
  wire [4:0] trip_code = config_reg[`PROBE_TRIP_HI:`PROBE_TRIP_LO];
  wire [1:0] angle_code = config_reg[`ANGLE_HI:`ANGLE_LO];
  wire [1:0] repeat_code = config_reg[`REPEAT_HI:`REPEAT_LO];

  // Reserved codes stay stored so software reads back what it wrote; only the decode flags them.

  always_comb begin
    settings_next = '0;
    settings_next.startup_method_select =
      startup_method_select_t'(config_reg[`METHOD_HI:`METHOD_LO]);
    settings_next.ramp_code = ramp_code;
    settings_next.ramp_unlimited = (ramp_code == `RAMP_NO_LIMIT);
    settings_next.hold_time_ms = hold_time_lookup(config_reg[`HOLD_TIME_HI:`HOLD_TIME_LO]);
    settings_next.startup_hold_current_cap = hold_cap_lookup(hold_cap_code);
    settings_next.hold_cap_reserved = (hold_cap_code > `HOLD_CAP_LAST);
    settings_next.probe_pulse_rate = probe_rate_lookup(config_reg[`PROBE_RATE_HI:`PROBE_RATE_LO]);
    settings_next.probe_current_trip = probe_trip_lookup(trip_code);
    settings_next.probe_trip_reserved = (trip_code > `PROBE_TRIP_LAST);
    settings_next.probe_release_behaviour =
      probe_release_behaviour_t'(config_reg[`RELEASE_BIT]);
    settings_next.probe_angle_offset = 7'(angle_code * `ANGLE_STEP_DEG);
    settings_next.probe_averaging_count = {1'b0, repeat_code} + 3'h1;
    settings_next.open_loop_cap_source =
      open_loop_cap_source_t'(config_reg[`CAP_SOURCE_BIT]);
    settings_next.torque_current_rampdown_on = config_reg[`RAMPDOWN_BIT];
    settings_next.active_brake_on = config_reg[`ACTIVE_BRAKE_BIT];
    settings_next.reversal_profile_select = config_reg[`REVERSAL_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= `STARTUP1_RESET;
    end else begin
      config_reg <= config_next;
    end
  end

  // Every access completes with no wait state: ready is registered from setup, so it is high in the first access cycle and dropped after.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  // Read data is zero outside the access cycle so a stale word never lingers on the bus.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= read_load;
    end
  end

  // A miss is flagged for reads and writes alike; the write itself is already dropped by the decode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= error_load;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settings_reg <= '0;
    end else begin
      settings_reg <= settings_next;
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign settings = settings_reg;

endmodule

//--- hdl/startup_consts.svh
// Offsets, field positions, reset value, write mask and code limits of the start-up configuration bank.
// Overview of operation
// - Bits 30-29 select the start-up method.
// - Bits 28-25 set ramp rate; Fh unlimited.
// - Bits 24-21 pick rotor hold time.
// - Bits 20-17 hold current; Eh, Fh reserved.
// - Bits 16-14 set probe pulse rate.
// - Bits 13-9 probe trip; Fh upward reserved.
// - Bits 7-6 add 0-90 degree advance.
// - Bits 5-4 give probe repeat count.
// - Bit 3 picks open-loop cap source.
`ifndef STARTUP_CONSTS_SVH
`define STARTUP_CONSTS_SVH

`define STARTUP1_INDEX 12'h084
`define STARTUP1_ADDR (`STARTUP1_INDEX * 12'h004)
`define STARTUP1_RESET 32'h0000_0000
`define STARTUP1_WMASK 32'h7FFF_FFFF

`define METHOD_HI 30
`define METHOD_LO 29
`define RAMP_HI 28
`define RAMP_LO 25
`define HOLD_TIME_HI 24
`define HOLD_TIME_LO 21
`define HOLD_CAP_HI 20
`define HOLD_CAP_LO 17
`define PROBE_RATE_HI 16
`define PROBE_RATE_LO 14
`define PROBE_TRIP_HI 13
`define PROBE_TRIP_LO 9
`define RELEASE_BIT 8
`define ANGLE_HI 7
`define ANGLE_LO 6
`define REPEAT_HI 5
`define REPEAT_LO 4
`define CAP_SOURCE_BIT 3
`define RAMPDOWN_BIT 2
`define ACTIVE_BRAKE_BIT 1
`define REVERSAL_BIT 0

`define RAMP_NO_LIMIT 4'hF
`define HOLD_CAP_LAST 4'hD
`define PROBE_TRIP_LAST 5'h0E
`define ANGLE_STEP_DEG 7'h1E

`endif

//--- hdl/startup_pkg.sv
// Types shared by the start-up configuration bank and its users.
package startup_pkg;

  typedef enum logic [1:0] {
    START_SINGLE_ALIGN,
    START_DOUBLE_ALIGN,
    START_POSITION_PROBE,
    START_SLOW_FIRST_CYCLE
  } startup_method_select_t;

  typedef enum logic {
    RELEASE_BRAKE,
    RELEASE_TRISTATE
  } probe_release_behaviour_t;

  typedef enum logic {
    CAP_FROM_OPEN_LOOP,
    CAP_FROM_GENERAL
  } open_loop_cap_source_t;

  // Decoded settings handed to the start-up sequencer; currents are in 1/128 A.
  typedef struct packed {
    startup_method_select_t startup_method_select;
    logic [3:0] ramp_code;
    logic ramp_unlimited;
    logic [13:0] hold_time_ms;
    logic [8:0] startup_hold_current_cap;
    logic hold_cap_reserved;
    logic [13:0] probe_pulse_rate;
    logic [8:0] probe_current_trip;
    logic probe_trip_reserved;
    probe_release_behaviour_t probe_release_behaviour;
    logic [6:0] probe_angle_offset;
    logic [2:0] probe_averaging_count;
    open_loop_cap_source_t open_loop_cap_source;
    logic torque_current_rampdown_on;
    logic active_brake_on;
    logic reversal_profile_select;
  } startup_settings_t;

endpackage

//--- dv/motor_startup_config_bank_props.sv
// Port-level checks of the start-up configuration bank.
`timescale 1ns/1ps
`include "startup_consts.svh"
module motor_startup_config_bank_props import startup_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus and settings
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire startup_settings_t settings
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A clean read shows the stored word, so the decoded outputs must agree with it.
  wire rd_ok = pready && !pwrite && !pslverr;
  a_method_follows: assert property (rd_ok |-> settings.startup_method_select == prdata[30:29])
    else $error("method decode wrong");
  a_ramp_free: assert property (rd_ok |-> settings.ramp_unlimited == (prdata[28:25] == 4'hF))
    else $error("ramp limit flag wrong");
  a_hold_first: assert property (rd_ok && prdata[24:21] == 4'h0 |-> settings.hold_time_ms == 14'h00A)
    else $error("hold time wrong");
  a_cap_reserved: assert property (rd_ok |-> settings.hold_cap_reserved == (prdata[20:17] > 4'hD))
    else $error("hold cap flag wrong");
  a_rate_top: assert property (rd_ok && prdata[16:14] == 3'h7 |-> settings.probe_pulse_rate == 14'h2710)
    else $error("pulse rate wrong");
  a_trip_reserved: assert property (rd_ok |-> settings.probe_trip_reserved == (prdata[13:9] > 5'h0E))
    else $error("trip flag wrong");
  a_release_mode: assert property (rd_ok |-> settings.probe_release_behaviour == prdata[8])
    else $error("release mode wrong");
  a_angle_step: assert property (rd_ok |-> settings.probe_angle_offset == 7'(prdata[7:6] * 30))
    else $error("angle wrong");
  a_repeat_count: assert property (rd_ok |-> settings.probe_averaging_count == 3'(prdata[5:4] + 1))
    else $error("repeat count wrong");
  a_cap_source: assert property (rd_ok |-> settings.open_loop_cap_source == prdata[3])
    else $error("cap source wrong");
  a_top_zero: assert property (psel && !penable |=> pready && !prdata[31] ##1 !pready)
    else $error("access or bit 31 wrong");
endmodule
bind motor_startup_config_bank motor_startup_config_bank_props #(.ADDR_W(ADDR_W)) props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .settings(settings));

//--- dv/motor_startup_config_bank_tb_top.sv
// Self-checking bench of the start-up configuration bank.
`timescale 1ns/1ps
`include "startup_consts.svh"
module motor_startup_config_bank_tb_top import startup_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, w;
  logic [3:0] pstrb = 4'h0;
  startup_settings_t settings;
  int err_count = 0, checked = 0, cycles = 0;
  localparam logic [11:0] A = `STARTUP1_ADDR;
  localparam logic [13:0] HT [16] = '{14'h00A, 14'h032, 14'h064, 14'h0C8, 14'h12C, 14'h190, 14'h1F4, 14'h2EE,
    14'h3E8, 14'h5DC, 14'h7D0, 14'hBB8, 14'hFA0, 14'h1388, 14'h1D4C, 14'h2710};
  localparam logic [8:0] CAP [16] = '{9'h00A, 9'h014, 9'h028, 9'h050, 9'h078, 9'h0A0, 9'h0C8, 9'h0F0,
    9'h118, 9'h140, 9'h168, 9'h190, 9'h1B8, 9'h1E0, 9'h000, 9'h000};
  localparam logic [13:0] PR [8] = '{14'h032, 14'h064, 14'h0FA, 14'h1F4, 14'h3E8, 14'h7D0, 14'h1388, 14'h2710};
  localparam logic [8:0] TR [16] = '{9'h014, 9'h028, 9'h03C, 9'h050, 9'h064, 9'h078, 9'h0A0, 9'h0C8,
    9'h0F0, 9'h125, 9'h140, 9'h168, 9'h190, 9'h1AB, 9'h1E0, 9'h000};
  motor_startup_config_bank motor_startup_config_bank_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .settings(settings));
  always #2 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // A hung handshake must end the run instead of stalling it.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles > 2000) begin
      err_count++;
      end_sim;
    end
  end
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, wr, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait that never sees ready.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Settings follow a write one edge after the access completes.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
    @(posedge pclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_reset;
    apb(1'b0, A, 32'h0, 4'h0);
    chk(rd === 32'h0 && er === 1'b0, "reset value");
    chk(settings.hold_time_ms === 14'h00A && settings.probe_pulse_rate === 14'h032, "reset decode");
  endtask
  task automatic s_modes;
    for (int i = 0; i < 4; i++) begin
      w = (i << 29) | (i << 6) | (i << 4) | ((i & 1) << 8) | ((i & 1) << 3);
      wr(A, w, 4'hF);
      chk(settings.startup_method_select === i[1:0], "method");
      chk(settings.probe_angle_offset === 7'(i * 30), "angle");
      chk(settings.probe_averaging_count === 3'(i + 1), "repeat");
      chk(settings.probe_release_behaviour === i[0], "release");
      chk(settings.open_loop_cap_source === i[0], "cap source");
      apb(1'b0, A, 32'h0, 4'h0);
      chk(rd === w && er === 1'b0, "mode readback");
    end
  endtask
  task automatic s_tables;
    for (int i = 0; i < 16; i++) begin
      w = (i << 25) | (i << 21) | (i << 17) | ((i & 7) << 14) | (i << 9);
      wr(A, w, 4'hF);
      chk(settings.ramp_unlimited === (i == 15) && settings.ramp_code === i[3:0], "ramp");
      chk(settings.hold_time_ms === HT[i], "hold time");
      chk(settings.startup_hold_current_cap === CAP[i] && settings.hold_cap_reserved === (i > 13), "cap");
      chk(settings.probe_pulse_rate === PR[i & 7], "rate");
      chk(settings.probe_current_trip === TR[i] && settings.probe_trip_reserved === (i > 14), "trip");
      apb(1'b0, A, 32'h0, 4'h0);
    end
    wr(A, 32'h0000_3E00, 4'hF);
    chk(settings.probe_trip_reserved === 1'b1 && settings.probe_current_trip === 9'h000, "trip top");
  endtask
  task automatic s_bits;
    wr(A, 32'hFFFF_FFFF, 4'hF);
    chk(settings.torque_current_rampdown_on === 1'b1, "rampdown set");
    chk(settings.active_brake_on === 1'b1 && settings.reversal_profile_select === 1'b1, "brake bits set");
    apb(1'b0, A, 32'h0, 4'h0);
    chk(rd === 32'h7FFF_FFFF, "bit 31 kept zero");
    wr(A, 32'h0, 4'h1);
    wr(A + 12'h004, 32'h0, 4'hF);
    chk(er === 1'b1, "unmapped write error");
    apb(1'b0, A, 32'h0, 4'h0);
    chk(rd === 32'h7FFF_FF00, "lane write");
    chk(settings.torque_current_rampdown_on === 1'b0, "rampdown clear");
    chk(settings.active_brake_on === 1'b0 && settings.reversal_profile_select === 1'b0, "brake bits clear");
    apb(1'b0, A + 12'h004, 32'h0, 4'h0);
    chk(rd === 32'h0 && er === 1'b1, "unmapped read");
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A, 32'h0, 4'h0);
    chk(rd === 32'h0 && settings.probe_current_trip === 9'h014, "second reset");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    s_reset;
    s_modes;
    s_tables;
    s_bits;
    end_sim;
  end
endmodule
